// ---- hw/pol_edge_det.sv ----
`timescale 1ns/1ps
module pol_edge_det
    import pol_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic level_in,
    output logic      rise_out,
    output logic      fall_out
);
    logic prev;
    logic next_prev;

    always_comb
    begin
        next_prev = level_in;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        // Strobe idles high; starting high avoids a false edge after reset
        if (rst_in)
            prev <= 1'b1;
        else
            prev <= next_prev;
    end

    assign rise_out = level_in & ~prev;
    assign fall_out = ~level_in & prev;
endmodule // pol_edge_det

// ---- hw/pol_loader.sv ----
`timescale 1ns/1ps
// How it works
// - Strobe low means configuration-slave mode; otherwise options come from pins.
// - Pin mode latches option pin levels when power-on reset releases.
// - PCI resets never change latched options; a bus hard reset changes them only through a strobed word.
// - Arbiter options: 1 internal, 0 external; from range pins or word bits 0-2.
// - PCI-2 primary when option pin 5 low or word bit 3 set.
// - Wide-path option pulses PCI-1 64-bit request while PCI-1 reset asserted.
// - Boot from PCI when option pin 3 low or word bit 5 set.
// - Word bits 0..7 map to options in order; bit 6 legacy core mode.
// - PLL bypass when option pin 1 low or word bit 7 set.
// - Single-PCI variant forces PCI-2 arbiter off and PCI-1 primary.
// - During power-on reset speed pins keep their PLL range function.
// - During power-on reset interrupt pins 5..1 are option inputs.
// - Slave mode samples pins first, then the strobed word replaces them.
// - Every hard-reset sequence resends the word; device relatches each time.
// - No 64-bit request while the strobe is low and the configuration word is not yet latched.
// - Latched options are readable in the options register; reset status is a separate register.
// - Power-on and bus hard resets assert asynchronously; release is synchronised to the clock.
module pol_loader
    import pol_pkg::*;
#(
    parameter bit SINGLE_PCI = 1'b0
)
(
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        power_on_reset_n_in,
    input  wire logic        proc_bus_hard_reset_n_in,
    input  wire logic        pci1_reset_n_in,
    input  wire logic        pci2_reset_n_in,
    input  wire logic        config_strobe_n_in,
    input  wire logic [7:0]  proc_data_bus_in,
    input  wire logic        proc_pll_range_sel_in,
    input  wire logic        pci1_speed_sel_in,
    input  wire logic        pci2_speed_sel_in,
    input  wire logic [5:1]  int_n_in,
    input  wire logic [5:1]  int_n_drive_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    output logic [5:1]       int_n_out,
    output logic [5:1]       int_n_oe_out,
    output logic [2:0]       pll_range_out,
    output logic             proc_arbiter_opt_out,
    output logic             pci1_arbiter_opt_out,
    output logic             pci2_arbiter_opt_out,
    output logic             primary_segment_opt_out,
    output logic             wide_path_announce_opt_out,
    output logic             boot_source_opt_out,
    output logic             legacy_core_mode_opt_out,
    output logic             pll_bypass_opt_out,
    output logic             pci1_req64_n_out,
    output logic             pci1_req64_oe_out
);
    logic                 por_arst_n;
    logic                 por_sync_n;
    logic                 por_rel;
    logic                 hr_sync_n;
    logic [OPT_COUNT-1:0] opts;
    logic [OPT_COUNT-1:0] next_opts;
    logic [OPT_COUNT-1:0] pin_opts;
    logic                 word_latched;
    logic                 next_word_latched;
    logic                 word_seen;
    logic                 next_word_seen;
    logic                 strobe_fall;
    logic                 unused_rise;
    logic [31:0]          next_rdata;
    logic [31:0]          rdata;
    pol_ann_state_t       ann;
    pol_ann_state_t       next_ann;
    logic [3:0]           ann_cnt;
    logic [3:0]           next_ann_cnt;
    logic                 req64_n;
    logic                 next_req64_n;
    logic                 req64_oe;
    logic                 next_req64_oe;
    logic [2:0]           pll_range;
    logic [2:0]           next_pll_range;
    logic                 opt_phase;

    assign por_arst_n = power_on_reset_n_in & ~sys_rst_in;

    pol_rst_sync u_por_sync (
        .clk_in    (core_clk_in),
        .arst_n_in (por_arst_n),
        .rst_n_out (por_sync_n)
    );

    pol_rst_sync u_hr_sync (
        .clk_in    (core_clk_in),
        .arst_n_in (proc_bus_hard_reset_n_in),
        .rst_n_out (hr_sync_n)
    );

    // Strobe is compared with its registered previous level; a falling edge during hard reset is the load
    pol_edge_det u_strobe (
        .clk_in   (core_clk_in),
        .rst_in   (sys_rst_in),
        .level_in (config_strobe_n_in),
        .rise_out (unused_rise),
        .fall_out (strobe_fall)
    );

    // Power-on reset release is seen as the first cycle with the sync high
    logic por_prev;
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            por_prev <= 1'b0;
        else
            por_prev <= por_sync_n;
    end
    assign por_rel   = por_sync_n & ~por_prev;
    assign opt_phase = ~por_sync_n;

    // Pin-mode option decode, active-low option pins inverted
    always_comb
    begin
        pin_opts               = '0;
        pin_opts[OPT_PROC_ARB] = proc_pll_range_sel_in;
        pin_opts[OPT_PCI1_ARB] = pci1_speed_sel_in;
        pin_opts[OPT_PCI2_ARB] = pci2_speed_sel_in;
        pin_opts[OPT_PRIMARY]  = ~int_n_in[5];
        pin_opts[OPT_WIDE]     = ~int_n_in[4];
        pin_opts[OPT_BOOT]     = ~int_n_in[3];
        pin_opts[OPT_LEGACY]   = ~int_n_in[2];
        pin_opts[OPT_BYPASS]   = ~int_n_in[1];
    end

    // Option store: only power-up release and a strobed load during hard reset write it; PCI resets leave it alone
    always_comb
    begin
        next_opts         = opts;
        next_word_latched = word_latched;
        next_word_seen    = word_seen;
        if (por_rel)
        begin
            next_opts         = pin_opts;
            next_word_latched = 1'b0;
        end
        else if (!hr_sync_n)
        begin
            if (strobe_fall)
            begin
                next_opts         = proc_data_bus_in;
                next_word_latched = 1'b1;
                next_word_seen    = 1'b1;
            end
        end
        // Without a strobe nothing is written, latched values stay
        if (SINGLE_PCI)
        begin
            next_opts[OPT_PCI2_ARB] = 1'b0;
            next_opts[OPT_PRIMARY]  = 1'b0;
        end
    end

    // Options sit on the system reset domain only
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            opts         <= OPTIONS_RESET;
            word_latched <= 1'b0;
            word_seen    <= 1'b0;
        end
        else
        begin
            opts         <= next_opts;
            word_latched <= next_word_latched;
            word_seen    <= next_word_seen;
        end
    end

    // Speed pins steer PLL range while power-on reset is held
    always_comb
    begin
        next_pll_range = pll_range;
        if (opt_phase)
            next_pll_range = {pci2_speed_sel_in, pci1_speed_sel_in,
                              proc_pll_range_sel_in};
    end

    // Wide-path announce: waits while strobe is low and no word is latched, pulses in PCI-1 reset
    always_comb
    begin
        next_ann      = ann;
        next_ann_cnt  = ann_cnt;
        next_req64_n  = 1'b1;
        next_req64_oe = 1'b0;
        case (ann)
            POL_IDLE:
            begin
                if (por_sync_n && opts[OPT_WIDE])
                    next_ann = POL_WAIT;
            end
            POL_WAIT:
            begin
                // Holds off only while the strobe is low and no word is latched
                if (!pci1_reset_n_in && (config_strobe_n_in || word_latched))
                begin
                    next_ann     = POL_PULSE;
                    next_ann_cnt = 4'(ANNOUNCE_CYCLES);
                end
                if (!opts[OPT_WIDE])
                    next_ann = POL_IDLE;
            end
            POL_PULSE:
            begin
                next_req64_n  = 1'b0;
                next_req64_oe = 1'b1;
                next_ann_cnt  = ann_cnt - 4'h1;
                if (pci1_reset_n_in || ann_cnt == 4'h0)
                begin
                    next_req64_n  = 1'b1;
                    next_req64_oe = 1'b0;
                    next_ann      = POL_DONE;
                end
            end
            POL_DONE:
            begin
                // Rearm for the next PCI-1 reset
                if (pci1_reset_n_in)
                    next_ann = POL_IDLE;
            end
            default:
                next_ann = POL_IDLE;
        endcase
    end

    // A fresh strobe could still change the option after the pulse; a limitation
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ann       <= POL_IDLE;
            ann_cnt   <= 4'h0;
            req64_n   <= 1'b1;
            req64_oe  <= 1'b0;
            pll_range <= 3'h0;
        end
        else
        begin
            ann       <= next_ann;
            ann_cnt   <= next_ann_cnt;
            req64_n   <= next_req64_n;
            req64_oe  <= next_req64_oe;
            pll_range <= next_pll_range;
        end
    end

    // Register read port, one cycle latency
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (rd_in)
        begin
            if (addr_in == ADDR_OPTIONS)
                next_rdata = {24'h00_0000, opts};
            else if (addr_in == ADDR_STATUS)
                next_rdata = {28'h000_0000, ~pci2_reset_n_in, word_seen,
                              word_latched, por_sync_n};
            else
                next_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            rdata <= 32'h0000_0000;
        else
            rdata <= next_rdata;
    end

    // Interrupt pins: released as options in reset, driven from core afterwards
    logic [5:1] int_q;
    logic [5:1] int_oe_q;
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            int_q    <= 5'h1F;
            int_oe_q <= 5'h00;
        end
        else
        begin
            int_q    <= 5'h00;
            int_oe_q <= opt_phase ? 5'h00 : int_n_drive_in;
        end
    end

    assign rdata_out                  = rdata;
    assign int_n_out                  = int_q;
    assign int_n_oe_out               = int_oe_q;
    assign pll_range_out              = pll_range;
    assign proc_arbiter_opt_out       = opts[OPT_PROC_ARB];
    assign pci1_arbiter_opt_out       = opts[OPT_PCI1_ARB];
    assign pci2_arbiter_opt_out       = opts[OPT_PCI2_ARB];
    assign primary_segment_opt_out    = opts[OPT_PRIMARY];
    assign wide_path_announce_opt_out = opts[OPT_WIDE];
    assign boot_source_opt_out        = opts[OPT_BOOT];
    assign legacy_core_mode_opt_out   = opts[OPT_LEGACY];
    assign pll_bypass_opt_out         = opts[OPT_BYPASS];
    assign pci1_req64_n_out           = req64_n;
    assign pci1_req64_oe_out          = req64_oe;
endmodule // pol_loader

// ---- hw/pol_pkg.sv ----
package pol_pkg;
    // Option bit positions, same order as the configuration word
    localparam int OPT_PROC_ARB   = 0;
    localparam int OPT_PCI1_ARB   = 1;
    localparam int OPT_PCI2_ARB   = 2;
    localparam int OPT_PRIMARY    = 3;
    localparam int OPT_WIDE       = 4;
    localparam int OPT_BOOT       = 5;
    localparam int OPT_LEGACY     = 6;
    localparam int OPT_BYPASS     = 7;
    localparam int OPT_COUNT      = 8;
    localparam int SYNC_STAGES    = 2;
    // Register map, word index in the read/write space
    localparam logic [3:0] ADDR_OPTIONS = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h1;
    localparam logic [7:0] OPTIONS_RESET = 8'h00;
    // Announce pulse length on the PCI-1 64-bit request, in clock cycles
    localparam int ANNOUNCE_CYCLES = 4;
    typedef enum logic [1:0] {
        POL_IDLE,
        POL_WAIT,
        POL_PULSE,
        POL_DONE
    } pol_ann_state_t;
endpackage

// ---- hw/pol_rst_sync.sv ----
`timescale 1ns/1ps
module pol_rst_sync
    import pol_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    output logic      rst_n_out
);
    logic [SYNC_STAGES-1:0] stages;
    logic [SYNC_STAGES-1:0] next_stages;

    always_comb
    begin
        next_stages = {stages[SYNC_STAGES-2:0], 1'b1};
    end

    // Assertion is immediate, release waits for the clock
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            stages <= '0;
        else
            stages <= next_stages;
    end

    assign rst_n_out = stages[SYNC_STAGES-1];
endmodule // pol_rst_sync

// ---- sim/pol_cfg_master.sv ----
`timescale 1ns/1ps
module pol_cfg_master
#(
    parameter int SLOT = 1
)
(
    input  wire logic       clk_in,
    output logic            hard_reset_n_out,
    output logic            strobe_n_out,
    output logic [7:0]      data_out
);
    initial
    begin
        hard_reset_n_out = 1'b1;
        strobe_n_out = 1'b1;
        data_out = 8'h3c;
    end
    // Other slots carry other words, so a late sample would see wrong data
    task automatic run(input logic [7:0] w, input logic hr, input logic st);
        @(posedge clk_in);
        hard_reset_n_out <= !hr;
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < 7; i++)
        begin
            data_out <= (i == SLOT) ? w : ~w;
            strobe_n_out <= !(st && i == SLOT);
            repeat (2) @(posedge clk_in);
            strobe_n_out <= 1'b1;
            repeat (2) @(posedge clk_in);
        end
        data_out <= ~data_out;
        hard_reset_n_out <= 1'b1;
    endtask
endmodule // pol_cfg_master

// ---- sim/pol_loader_sva.sv ----
`timescale 1ns/1ps
module pol_loader_sva
    import pol_pkg::*;
#(
    parameter bit SINGLE_PCI = 1'b0
)
(
    input wire logic        core_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        power_on_reset_n_in,
    input wire logic        proc_bus_hard_reset_n_in,
    input wire logic        pci1_reset_n_in,
    input wire logic        config_strobe_n_in,
    input wire logic [7:0]  proc_data_bus_in,
    input wire logic [3:0]  addr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [5:1]  int_n_oe_out,
    input wire logic        proc_arbiter_opt_out,
    input wire logic        pci1_arbiter_opt_out,
    input wire logic        pci2_arbiter_opt_out,
    input wire logic        primary_segment_opt_out,
    input wire logic        wide_path_announce_opt_out,
    input wire logic        boot_source_opt_out,
    input wire logic        legacy_core_mode_opt_out,
    input wire logic        pll_bypass_opt_out,
    input wire logic        pci1_req64_n_out,
    input wire logic        pci1_req64_oe_out
);
    wire [7:0] opts = {pll_bypass_opt_out, legacy_core_mode_opt_out, boot_source_opt_out,
        wide_path_announce_opt_out, primary_segment_opt_out, pci2_arbiter_opt_out,
        pci1_arbiter_opt_out, proc_arbiter_opt_out};
    // Single-PCI build keeps the PCI-2 arbiter and primary options at zero
    localparam logic [7:0] LOAD_MASK = SINGLE_PCI ?
        ~((8'h01 << OPT_PCI2_ARB) | (8'h01 << OPT_PRIMARY)) : 8'hff;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Six quiet cycles cover the synchroniser delay on both resets
    sequence quiet_s;
        (power_on_reset_n_in && proc_bus_hard_reset_n_in)[*6];
    endsequence
    sequence load_s;
        (!proc_bus_hard_reset_n_in && power_on_reset_n_in)[*4] ##0 $fell(config_strobe_n_in);
    endsequence
    oe_off_por_a: assert property (
        (!power_on_reset_n_in)[*2] |-> int_n_oe_out == 5'h00)
        else $error("interrupt pins driven during power-on reset");
    opts_hold_a: assert property (quiet_s |-> $stable(opts))
        else $error("options changed outside power-up or load");
    word_load_a: assert property (
        load_s |-> ##[1:2] opts == (proc_data_bus_in & LOAD_MASK))
        else $error("strobed word not taken into options");
    single_pci_a: assert property (
        SINGLE_PCI |-> !pci2_arbiter_opt_out && !primary_segment_opt_out)
        else $error("single-PCI build shows PCI-2 options");
    req64_cause_a: assert property ($fell(pci1_req64_n_out) |->
        wide_path_announce_opt_out && pci1_req64_oe_out && $past(!pci1_reset_n_in))
        else $error("announce pulse without its cause");
    req64_len_a: assert property (
        $fell(pci1_req64_n_out) |-> ##[1:4] pci1_req64_n_out)
        else $error("announce pulse too long");
    read_opts_a: assert property (rd_in && addr_in == ADDR_OPTIONS |=>
        rdata_out == {24'h00_0000, $past(opts)})
        else $error("option read mismatch");
    read_idle_a: assert property (!rd_in |=> rdata_out == 32'h0000_0000)
        else $error("read data outside read slot");
    read_unmap_a: assert property (
        rd_in && addr_in > ADDR_STATUS |=> !(|rdata_out))
        else $error("unmapped read not zero");
endmodule // pol_loader_sva

// ---- sim/tb_pol_loader.sv ----
`timescale 1ns/1ps
module tb_pol_loader;
    import pol_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        por_n = 1'b0;
    logic        pci1_n = 1'b1;
    logic        pci2_n = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  spd = 3'h0;
    logic [5:1]  int_n = 5'h1f;
    logic [5:1]  drv = 5'h15;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdata;
    logic [7:0]  opt;
    logic [2:0]  pll;
    logic [5:1]  ioe;
    logic [5:1]  intn;
    logic [1:0]  sp_opt;
    logic        r64n;
    logic        r64oe;
    wire         hr_n;
    wire         stb_n;
    wire  [7:0]  pbd;
    int          n_mismatch = 0;
    int          n_tests = 0;
    pol_loader u_dut (.core_clk_in(clk), .sys_rst_in(rst), .power_on_reset_n_in(por_n),
        .proc_bus_hard_reset_n_in(hr_n), .pci1_reset_n_in(pci1_n), .pci2_reset_n_in(pci2_n),
        .config_strobe_n_in(stb_n), .proc_data_bus_in(pbd), .proc_pll_range_sel_in(spd[0]),
        .pci1_speed_sel_in(spd[1]), .pci2_speed_sel_in(spd[2]), .int_n_in(int_n),
        .int_n_drive_in(drv), .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .int_n_out(intn), .int_n_oe_out(ioe), .pll_range_out(pll),
        .proc_arbiter_opt_out(opt[0]), .pci1_arbiter_opt_out(opt[1]),
        .pci2_arbiter_opt_out(opt[2]), .primary_segment_opt_out(opt[3]),
        .wide_path_announce_opt_out(opt[4]), .boot_source_opt_out(opt[5]),
        .legacy_core_mode_opt_out(opt[6]), .pll_bypass_opt_out(opt[7]),
        .pci1_req64_n_out(r64n), .pci1_req64_oe_out(r64oe));
    pol_loader #(.SINGLE_PCI(1'b1)) u_dut_sp (.core_clk_in(clk), .sys_rst_in(rst),
        .power_on_reset_n_in(por_n), .proc_bus_hard_reset_n_in(hr_n),
        .pci1_reset_n_in(pci1_n), .pci2_reset_n_in(pci2_n), .config_strobe_n_in(stb_n),
        .proc_data_bus_in(pbd), .proc_pll_range_sel_in(spd[0]), .pci1_speed_sel_in(spd[1]),
        .pci2_speed_sel_in(spd[2]), .int_n_in(int_n), .int_n_drive_in(drv), .addr_in(addr),
        .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(), .int_n_out(), .int_n_oe_out(),
        .pll_range_out(), .proc_arbiter_opt_out(), .pci1_arbiter_opt_out(),
        .pci2_arbiter_opt_out(sp_opt[0]), .primary_segment_opt_out(sp_opt[1]),
        .wide_path_announce_opt_out(), .boot_source_opt_out(), .legacy_core_mode_opt_out(),
        .pll_bypass_opt_out(), .pci1_req64_n_out(), .pci1_req64_oe_out());
    pol_cfg_master #(.SLOT(1)) u_mst (.clk_in(clk), .hard_reset_n_out(hr_n),
        .strobe_n_out(stb_n), .data_out(pbd));
    initial
        forever #4 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    function automatic logic [7:0] pin_opts(input logic [5:1] p, input logic [2:0] s);
        return {~p[1], ~p[2], ~p[3], ~p[4], ~p[5], s};
    endfunction
    task automatic power_up(input logic [5:1] p, input logic [2:0] s);
        logic [31:0] d;
        @(posedge clk);
        por_n <= 1'b0;
        int_n <= p;
        spd <= s;
        repeat (4) @(posedge clk);
        #1 chk(ioe, 5'h00);
        chk(pll, s);
        @(posedge clk) por_n <= 1'b1;
        repeat (6) @(posedge clk);
        int_n <= 5'h1f;
        #1 chk(opt, pin_opts(p, s));
        chk(ioe, drv);
        chk(intn, 5'h00);
        chk(sp_opt, 2'h0);
        rd_reg(ADDR_OPTIONS, d);
        chk(d, {24'h00_0000, pin_opts(p, s)});
    endtask
    task automatic t_pins();
        logic [5:1] p [3] = '{5'h1f, 5'h00, 5'h0a};
        logic [2:0] s [3] = '{3'h0, 3'h7, 3'h5};
        for (int i = 0; i < 3; i++)
            power_up(p[i], s[i]);
        $display("t_pins done");
    endtask
    task automatic t_resets();
        logic [31:0] d;
        @(posedge clk);
        pci1_n <= 1'b0;
        pci2_n <= 1'b0;
        wr <= 1'b1;
        wd <= 32'hffff_ffff;
        @(posedge clk) wr <= 1'b0;
        rd_reg(ADDR_STATUS, d);
        chk({d[3], d[0]}, 2'h3);
        @(posedge clk);
        pci1_n <= 1'b1;
        pci2_n <= 1'b1;
        u_mst.run(8'hff, 1'b1, 1'b0);
        u_mst.run(8'hff, 1'b0, 1'b1);
        repeat (4) @(posedge clk);
        #1 chk(opt, pin_opts(5'h0a, 3'h5));
        rd_reg(4'hf, d);
        chk(d, 32'h0000_0000);
        $display("t_resets done");
    endtask
    task automatic t_slave();
        for (int i = 0; i < 2; i++)
        begin
            if (i == 1)
                power_up(5'h1f, 3'h0);
            u_mst.run(8'ha6, 1'b1, 1'b1);
            repeat (2) @(posedge clk);
            #1 chk(opt, 8'ha6);
            chk(sp_opt, 2'h0);
        end
        $display("t_slave done");
    endtask
    task automatic t_announce();
        int n;
        for (int w = 0; w < 2; w++)
        begin
            power_up((w == 1) ? 5'h17 : 5'h1f, 3'h0);
            n = 0;
            @(posedge clk) pci1_n <= 1'b0;
            for (int c = 0; c < 20; c++)
            begin
                @(posedge clk);
                #1 n += (r64n === 1'b0 && r64oe === 1'b1) ? 1 : 0;
            end
            @(posedge clk) pci1_n <= 1'b1;
            chk(n, (w == 1) ? ANNOUNCE_CYCLES : 0);
        end
        $display("t_announce done");
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_pins();
        t_resets();
        t_slave();
        t_announce();
        wrap_up();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule // tb_pol_loader
bind pol_loader pol_loader_sva #(.SINGLE_PCI(SINGLE_PCI)) u_sva (.*);
